// File: logic/tsp_pkg.sv
package tsp_pkg;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEOUT_MS = 30;
  // longest time, so the division rounds down
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

  // address-select strap codes and the slave address each one gives
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SUPPLY = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;
  localparam logic [6:0] ADDR_GND = 7'h48;
  localparam logic [6:0] ADDR_SUPPLY = 7'h49;
  localparam logic [6:0] ADDR_SDA = 7'h4a;
  localparam logic [6:0] ADDR_SCL = 7'h4b;

  // special bus bytes
  localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
  localparam logic [7:0] GEN_RESET_CMD = 8'h06;
  localparam logic [7:0] ALERT_RESP_BYTE = 8'h19;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;

  // pointer select codes
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // power-up values
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] UPPER_RESET = 16'h0000;

  // bit counts
  localparam logic [3:0] RX_LAST = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;

  typedef enum logic [2:0] {
    st_idle, st_rx, st_rx_ack, st_tx, st_tx_ack
  } tsp_state_t;

  typedef enum logic [2:0] {
    ph_addr, ph_ptr, ph_data_hi, ph_data_lo, ph_gcmd, ph_read, ph_alert
  } tsp_phase_t;

endpackage : tsp_pkg

// File: logic/tsp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  // lines idle high, so reset to ones to avoid a false start after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= '1;
      o_sync <= '1;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : tsp_sync

`default_nettype wire

// File: logic/tsp_timeout.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_timeout #(
  parameter int LIMIT = tsp_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_expired
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] count;

  // counts only while run holds; any break restarts the wait from zero
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      count <= '0;
      o_expired <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      o_expired <= 1'b1;
    end else begin
      count <= count + CW'(1);
      o_expired <= 1'b0;
    end
  end

endmodule : tsp_timeout

`default_nettype wire

// File: logic/tsp_slave.sv
// How it works
// R1 - slave only, never drives clock, pulls data
// R2 - bytes shift most significant bit first
// R3 - start, then seven address bits and direction
// R4 - address pin strap picks one of four
// R5 - matching address acknowledged on ninth clock
// R6 - first written byte loads the pointer
// R7 - pointer kept; reads use last written pointer
// R8 - controller rewrites pointer before reading elsewhere
// R9 - written bytes fill register, high first, acked
// R10 - read sends high byte, then low byte
// R11 - unlimited bytes; early end keeps upper byte
// R12 - data changes with clock low; start, stop
// R13 - interrupt mode alert: ack response, send address
// R14 - returned last bit gives cause, polarity inverts
// R15 - alert arbitration by address; winner clears alert
// R16 - general call acked; reset command restores registers
// R17 - address-acquire command ignored entirely
// R18 - high-speed code not acked, filters switch over
// R19 - high-speed held until stop, then fast mode
// R20 - clock low too long resets the interface
// R21 - controller keeps clock above time-out rate
// R22 - fast and high-speed clock rates supported
// R23 - pointer low bits select one of four registers
// R24 - pointer powers up selecting temperature
// R25 - temperature read clears alert in interrupt mode
// R26 - foreign addresses left unacknowledged
// R27 - stop or restart returns to address wait
`timescale 1ns/1ps
`default_nettype none

module tsp_slave #(
  parameter int P_TIMEOUT_CYCLES = tsp_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic [1:0] i_address_select_pin,
  input wire logic [15:0] i_temperature,
  input wire logic i_thermostat_mode_select,
  input wire logic i_alert_polarity,
  input wire logic i_alert_active,
  input wire logic i_alert_high_cause,
  output logic [7:0] o_pointer,
  output logic [15:0] o_config,
  output logic [15:0] o_lower_limit,
  output logic [15:0] o_upper_limit,
  output logic o_high_speed,
  output logic o_alert_clear,
  output logic o_general_reset
);

  logic [3:0] pins_s;
  logic [1:0] strap_s;
  logic scl_s, sda_s, scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic tmo, in_frame;
  logic [6:0] own_addr;
  tsp_pkg::tsp_state_t state;
  tsp_pkg::tsp_phase_t phase, next_phase;
  logic [3:0] bcnt;
  logic [7:0] rx_shift, tx_shift, tx_byte;
  logic tx_sel, alert_bit;
  logic [15:0] sel_reg;
  logic rx_decide, next_ack, ptr_wr, hi_wr, lo_wr;
  logic gc_hit, hs_hit, alert_won, temp_read;

  // scl, sda and the strap come from pins; an scl period needs about six clocks here [R22]
  tsp_sync #(
    .W(4)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_address_select_pin, i_scl, i_sda}),
    .o_sync(pins_s)
  );

  assign strap_s = pins_s[3:2];
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  // data moving while clock stays high marks start or stop [R12]
  assign bus_start = scl_s && scl_q && sda_q && !sda_s;
  assign bus_stop = scl_s && scl_q && !sda_q && sda_s;

  // strap is re-read only between frames, so a mid-frame glitch cannot move the address
  always_ff @(posedge i_clk) begin
    if (!in_frame) begin
      unique case (strap_s)
        tsp_pkg::STRAP_GND: own_addr <= tsp_pkg::ADDR_GND; // [R4]
        tsp_pkg::STRAP_SUPPLY: own_addr <= tsp_pkg::ADDR_SUPPLY;
        tsp_pkg::STRAP_SDA: own_addr <= tsp_pkg::ADDR_SDA;
        tsp_pkg::STRAP_SCL: own_addr <= tsp_pkg::ADDR_SCL;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || bus_stop || tmo) begin
      in_frame <= 1'b0;
    end else if (bus_start) begin
      in_frame <= 1'b1;
    end
  end

  // clock held low inside a frame for the time-out [R20]
  tsp_timeout #(
    .LIMIT(P_TIMEOUT_CYCLES)
  ) u_timeout (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(in_frame && !scl_s),
    .o_expired(tmo)
  );

  // register picked by the last written pointer [R7] [R23]
  always_comb begin
    unique case (o_pointer[1:0])
      tsp_pkg::PTR_TEMP: sel_reg = i_temperature;
      tsp_pkg::PTR_CONFIG: sel_reg = o_config;
      tsp_pkg::PTR_LOWER: sel_reg = o_lower_limit;
      tsp_pkg::PTR_UPPER: sel_reg = o_upper_limit;
    endcase
  end

  // low for a high-limit cause, flipped by polarity [R14]
  assign alert_bit = !i_alert_high_cause ^ i_alert_polarity;
  // alert answer carries own address; reads send high byte then low [R10] [R13]
  assign tx_byte = (phase == tsp_pkg::ph_alert) ? {own_addr, alert_bit} :
                   (tx_sel ? sel_reg[7:0] : sel_reg[15:8]);

  assign rx_decide = (state == tsp_pkg::st_rx) && scl_fall && (bcnt == tsp_pkg::RX_LAST) &&
                     !bus_start && !bus_stop && !tmo;

  // decision on each whole received byte
  always_comb begin
    next_ack = 1'b0;
    next_phase = phase;
    ptr_wr = 1'b0;
    hi_wr = 1'b0;
    lo_wr = 1'b0;
    gc_hit = 1'b0;
    hs_hit = 1'b0;
    unique case (phase)
      tsp_pkg::ph_addr: begin
        if (rx_shift[7:1] == own_addr) begin
          next_ack = 1'b1; // [R5]
          next_phase = rx_shift[0] ? tsp_pkg::ph_read : tsp_pkg::ph_ptr;
        end else if (rx_shift == tsp_pkg::GEN_CALL_BYTE) begin
          next_ack = 1'b1; // [R16]
          next_phase = tsp_pkg::ph_gcmd;
        end else if (rx_shift[7:3] == tsp_pkg::HS_CODE_PREFIX) begin
          hs_hit = 1'b1; // [R18]
        end else if (rx_shift == tsp_pkg::ALERT_RESP_BYTE && i_thermostat_mode_select && i_alert_active) begin
          next_ack = 1'b1; // [R13]
          next_phase = tsp_pkg::ph_alert;
        end
        // anything else stays unacknowledged [R26]
      end
      tsp_pkg::ph_ptr: begin
        next_ack = 1'b1;
        ptr_wr = 1'b1; // [R6]
        next_phase = tsp_pkg::ph_data_hi;
      end
      tsp_pkg::ph_data_hi: begin
        next_ack = 1'b1;
        hi_wr = 1'b1; // [R9]
        next_phase = tsp_pkg::ph_data_lo;
      end
      tsp_pkg::ph_data_lo: begin
        next_ack = 1'b1;
        lo_wr = 1'b1; // [R9] [R11]
        next_phase = tsp_pkg::ph_data_hi;
      end
      tsp_pkg::ph_gcmd: begin
        // only the reset command acts; address-acquire and the rest are refused [R17]
        if (rx_shift == tsp_pkg::GEN_RESET_CMD) begin
          next_ack = 1'b1;
          gc_hit = 1'b1; // [R16]
        end
      end
      tsp_pkg::ph_read, tsp_pkg::ph_alert: begin
        next_ack = 1'b0;
      end
    endcase
  end

  // byte engine; the data pin is only ever pulled low [R1]
  always_ff @(posedge i_clk) begin
    if (i_rst || bus_stop || tmo) begin
      state <= tsp_pkg::st_idle; // [R20] [R27]
      phase <= tsp_pkg::ph_addr;
      bcnt <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      tx_sel <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (bus_start) begin
      state <= tsp_pkg::st_rx; // [R3] [R27]
      phase <= tsp_pkg::ph_addr;
      bcnt <= '0;
      tx_sel <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (state)
        tsp_pkg::st_idle: begin
          o_sda_oe <= 1'b0;
        end
        tsp_pkg::st_rx: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_s}; // [R2] [R3]
            bcnt <= bcnt + 4'h1;
          end else if (rx_decide) begin
            phase <= next_phase;
            o_sda_oe <= next_ack; // [R5]
            state <= next_ack ? tsp_pkg::st_rx_ack : tsp_pkg::st_idle;
          end
        end
        tsp_pkg::st_rx_ack: begin
          // ack held through the ninth high phase, dropped on its falling edge
          if (scl_fall) begin
            bcnt <= '0;
            if (phase == tsp_pkg::ph_read || phase == tsp_pkg::ph_alert) begin
              tx_shift <= tx_byte;
              tx_sel <= !tx_sel;
              o_sda_oe <= !tx_byte[7];
              state <= tsp_pkg::st_tx;
            end else begin
              o_sda_oe <= 1'b0;
              state <= tsp_pkg::st_rx;
            end
          end
        end
        tsp_pkg::st_tx: begin
          if (scl_rise && phase == tsp_pkg::ph_alert && !o_sda_oe && !sda_s) begin
            o_sda_oe <= 1'b0; // lost arbitration [R15]
            state <= tsp_pkg::st_idle;
          end else if (scl_fall) begin
            if (bcnt == tsp_pkg::TX_LAST) begin
              o_sda_oe <= 1'b0;
              state <= tsp_pkg::st_tx_ack;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0}; // [R2]
              o_sda_oe <= !tx_shift[6];
              bcnt <= bcnt + 4'h1;
            end
          end
        end
        tsp_pkg::st_tx_ack: begin
          // controller nack, or end of the alert answer, finishes the transfer [R10]
          if (scl_rise && (sda_s || phase == tsp_pkg::ph_alert)) begin
            state <= tsp_pkg::st_idle;
          end else if (scl_fall) begin
            tx_shift <= tx_byte;
            tx_sel <= !tx_sel;
            o_sda_oe <= !tx_byte[7];
            bcnt <= '0;
            state <= tsp_pkg::st_tx;
          end
        end
      endcase
    end
  end

  assign o_sda = 1'b0;
  // pointer and writable registers; each byte lands as soon as it is acked [R11]
  always_ff @(posedge i_clk) begin
    if (i_rst || (rx_decide && gc_hit)) begin
      o_pointer <= tsp_pkg::POINTER_RESET; // [R16] [R24]
      o_config <= tsp_pkg::CONFIG_RESET;
      o_lower_limit <= tsp_pkg::LOWER_RESET;
      o_upper_limit <= tsp_pkg::UPPER_RESET;
    end else if (rx_decide) begin
      if (ptr_wr) begin
        o_pointer <= rx_shift; // [R6]
      end
      // temperature is read only, so writes aimed at it are dropped
      if (hi_wr || lo_wr) begin
        unique case (o_pointer[1:0])
          tsp_pkg::PTR_TEMP: ;
          tsp_pkg::PTR_CONFIG: begin
            if (hi_wr) o_config[15:8] <= rx_shift;
            else o_config[7:0] <= rx_shift;
          end
          tsp_pkg::PTR_LOWER: begin
            if (hi_wr) o_lower_limit[15:8] <= rx_shift;
            else o_lower_limit[7:0] <= rx_shift;
          end
          tsp_pkg::PTR_UPPER: begin
            if (hi_wr) o_upper_limit[15:8] <= rx_shift;
            else o_upper_limit[7:0] <= rx_shift;
          end
        endcase
      end
    end
  end

  // high-speed filters persist over repeated starts until stop or time-out [R18] [R19]
  always_ff @(posedge i_clk) begin
    if (i_rst || bus_stop || tmo) begin
      o_high_speed <= 1'b0;
    end else if (rx_decide && hs_hit) begin
      o_high_speed <= 1'b1;
    end
  end
  assign alert_won = (state == tsp_pkg::st_tx_ack) && (phase == tsp_pkg::ph_alert) && scl_rise &&
                     !bus_start && !bus_stop && !tmo;
  assign temp_read = rx_decide && next_ack && (next_phase == tsp_pkg::ph_read) &&
                     (o_pointer[1:0] == tsp_pkg::PTR_TEMP) && i_thermostat_mode_select;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alert_clear <= 1'b0;
      o_general_reset <= 1'b0;
    end else begin
      o_alert_clear <= alert_won || temp_read; // [R15] [R25]
      o_general_reset <= rx_decide && gc_hit; // [R16]
    end
  end

endmodule : tsp_slave

`default_nettype wire

// File: test/tsp_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_slave_properties #(
  parameter int P_TIMEOUT_CYCLES = tsp_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_thermostat_mode_select,
  input wire logic [7:0] o_pointer,
  input wire logic [15:0] o_config,
  input wire logic [15:0] o_lower_limit,
  input wire logic [15:0] o_upper_limit,
  input wire logic o_high_speed,
  input wire logic o_alert_clear,
  input wire logic o_general_reset
);
  // saturates so a long idle low clock cannot wrap round
  int low_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst || i_scl) begin
      low_cnt <= 0;
    end else if (low_cnt < P_TIMEOUT_CYCLES + 16) begin
      low_cnt <= low_cnt + 1;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence stop_seen;
    i_scl && !i_sda ##1 i_scl && i_sda;
  endsequence
  sequence ack_held;
    o_sda_oe [*3];
  endsequence

  sda_drive_low_a: assert property (o_sda == 1'b0) else $error("data out not low");
  sda_moves_low_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
    else $error("data moved with clock high");
  ack_stands_a: assert property ($rose(o_sda_oe) |=> ack_held) else $error("pull too short");
  clear_in_intr_a: assert property (o_alert_clear |-> i_thermostat_mode_select)
    else $error("alert clear outside interrupt mode");
  reset_loads_a: assert property (o_general_reset |-> ##[0:2] (o_pointer == tsp_pkg::POINTER_RESET &&
    o_config == tsp_pkg::CONFIG_RESET && o_lower_limit == tsp_pkg::LOWER_RESET &&
    o_upper_limit == tsp_pkg::UPPER_RESET)) else $error("registers not reloaded");
  regs_scl_low_a: assert property ($changed({o_pointer, o_config, o_lower_limit, o_upper_limit})
    |-> !$past(i_scl)) else $error("register moved with clock high");
  stop_ends_a: assert property (stop_seen |-> ##[1:6] (!o_sda_oe && !o_high_speed))
    else $error("stop did not end frame");
  timeout_free_a: assert property (low_cnt > P_TIMEOUT_CYCLES + 8 |-> !o_sda_oe && !o_high_speed)
    else $error("time-out did not release");
endmodule : tsp_slave_properties

bind tsp_slave tsp_slave_properties #(.P_TIMEOUT_CYCLES(P_TIMEOUT_CYCLES)) i_tsp_slave_properties (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .i_thermostat_mode_select(i_thermostat_mode_select), .o_pointer(o_pointer), .o_config(o_config),
  .o_lower_limit(o_lower_limit), .o_upper_limit(o_upper_limit), .o_high_speed(o_high_speed),
  .o_alert_clear(o_alert_clear), .o_general_reset(o_general_reset));

`default_nettype wire

// File: test/tsp_host.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_host (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic put_bit(input logic b, output logic r);
    o_sda_low = !b;
    #200 o_scl = 1'b1;
    #200 r = i_sda;
    #200 o_scl = 1'b0;
    #200;
  endtask : put_bit

  task automatic start();
    o_sda_low = 1'b0;
    #200 o_scl = 1'b1;
    #200 o_sda_low = 1'b1;
    #200 o_scl = 1'b0;
    #200;
  endtask : start

  task automatic stop();
    o_sda_low = 1'b1;
    #200 o_scl = 1'b1;
    #200 o_sda_low = 1'b0;
    #400;
  endtask : stop

  // all ones releases the line so the slave may send
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic ack_low);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(ak, a);
    ack_low = !a;
  endtask : xfer
endmodule : tsp_host

`default_nettype wire

// File: test/tsp_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tsp_slave_tb;
  localparam int TO = 200;
  localparam logic [7:0] AW = {tsp_pkg::ADDR_GND, 1'b0};
  localparam logic [7:0] AR = {tsp_pkg::ADDR_GND, 1'b1};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] strap = tsp_pkg::STRAP_GND;
  logic tm = 1'b0, alert_polarity = 1'b0, al_act = 1'b0, cause = 1'b1;
  logic scl, host_low, sda_oe, sda_out, hs, al_clr, g_rst, ak;
  logic [7:0] ptr, rd;
  logic [15:0] cfg, lo_lim, up_lim;
  int miscompares = 0, n_tests = 0, n_clr = 0, n_grst = 0;
  wire logic sda = !(host_low || sda_oe);

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (al_clr === 1'b1) n_clr++;
    if (g_rst === 1'b1) n_grst++;
  end

  tsp_slave #(.P_TIMEOUT_CYCLES(TO)) i_tsp_slave (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_out), .o_sda_oe(sda_oe), .i_address_select_pin(strap), .i_temperature(16'hc3a5),
    .i_thermostat_mode_select(tm), .i_alert_polarity(alert_polarity), .i_alert_active(al_act),
    .i_alert_high_cause(cause), .o_pointer(ptr), .o_config(cfg), .o_lower_limit(lo_lim),
    .o_upper_limit(up_lim), .o_high_speed(hs), .o_alert_clear(al_clr), .o_general_reset(g_rst));
  tsp_host i_tsp_host (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic ca(input logic e); chk(16'(ak), 16'(e)); endtask : ca
  task automatic cr(input logic [7:0] e); chk(16'(rd), 16'(e)); endtask : cr
  task automatic tick(input int n); repeat (n) @(posedge i_clk); #1; endtask : tick
  task automatic wr(input logic [7:0] d); i_tsp_host.xfer(d, 1'b1, rd, ak); endtask : wr
  task automatic rdb(input logic last); i_tsp_host.xfer(8'hff, last, rd, ak); endtask : rdb

  task automatic t_power_read();
    tm = 1'b1;
    i_tsp_host.start();
    wr(AR);
    ca(1'b1);
    rdb(1'b0);
    cr(8'hc3);
    rdb(1'b1);
    cr(8'ha5);
    i_tsp_host.stop();
    chk(16'(n_clr), 16'h1);
    tm = 1'b0;
  endtask : t_power_read

  task automatic t_strap();
    logic [6:0] ad [4];
    ad = '{tsp_pkg::ADDR_GND, tsp_pkg::ADDR_SUPPLY, tsp_pkg::ADDR_SDA, tsp_pkg::ADDR_SCL};
    for (int s = 0; s < 4; s++) begin
      strap = 2'(s);
      tick(5);
      i_tsp_host.start();
      wr({ad[s] ^ 7'h04, 1'b0});
      ca(1'b0);
      i_tsp_host.start();
      wr({ad[s], 1'b0});
      ca(1'b1);
      i_tsp_host.stop();
    end
    strap = tsp_pkg::STRAP_GND;
    tick(5);
  endtask : t_strap

  task automatic t_write();
    i_tsp_host.start();
    wr(AW);
    wr(8'h01);
    chk(16'(ptr), 16'h1);
    wr(8'ha5);
    ca(1'b1);
    wr(8'h3c);
    i_tsp_host.stop();
    chk(cfg, 16'ha53c);
    i_tsp_host.start();
    wr(AR);
    rdb(1'b0);
    cr(8'ha5);
    rdb(1'b1);
    cr(8'h3c);
    i_tsp_host.stop();
    i_tsp_host.start();
    wr(AW);
    wr(8'h02);
    wr(8'h5a);
    wr(8'h0f);
    i_tsp_host.stop();
    chk(lo_lim, 16'h5a0f);
    i_tsp_host.start();
    wr(AW);
    wr(8'h00);
    wr(8'h11);
    ca(1'b1);
    i_tsp_host.start();
    wr(AR);
    rdb(1'b0);
    cr(8'hc3);
    rdb(1'b1);
    cr(8'ha5);
    i_tsp_host.stop();
    chk(lo_lim, 16'h5a0f);
    chk(cfg, 16'ha53c);
    i_tsp_host.start();
    wr(AW);
    wr(8'h03);
    wr(8'h7e);
    i_tsp_host.start();
    wr(AR);
    rdb(1'b0);
    cr(8'h7e);
    rdb(1'b1);
    cr(8'h00);
    i_tsp_host.stop();
    chk(up_lim, 16'h7e00);
  endtask : t_write

  task automatic t_gcall();
    i_tsp_host.start();
    wr(8'h00);
    ca(1'b1);
    wr(8'h04);
    i_tsp_host.stop();
    chk(cfg, 16'ha53c);
    i_tsp_host.start();
    wr(8'h00);
    wr(8'h06);
    ca(1'b1);
    i_tsp_host.stop();
    chk(cfg, 16'h0);
    chk(up_lim, 16'h0);
    chk(lo_lim, 16'h0);
    chk(16'(ptr), 16'h0);
    chk(16'(n_grst), 16'h1);
  endtask : t_gcall

  task automatic t_hs();
    i_tsp_host.start();
    wr(8'h0b);
    ca(1'b0);
    chk(16'(hs), 16'h1);
    i_tsp_host.start();
    wr(AW);
    ca(1'b1);
    chk(16'(hs), 16'h1);
    i_tsp_host.stop();
    chk(16'(hs), 16'h0);
    i_tsp_host.start();
    wr(8'h08);
    i_tsp_host.start();
    tick(300);
    chk(16'(hs), 16'h0);
    i_tsp_host.start();
    wr(AW);
    ca(1'b1);
    i_tsp_host.stop();
  endtask : t_hs

  task automatic t_alert();
    int c0;
    tm = 1'b1;
    al_act = 1'b1;
    c0 = n_clr;
    for (int p = 0; p < 4; p++) begin
      alert_polarity = p[0];
      cause = p[1];
      i_tsp_host.start();
      wr(tsp_pkg::ALERT_RESP_BYTE);
      ca(1'b1);
      rdb(1'b1);
      cr({tsp_pkg::ADDR_GND, p[0] ~^ p[1]});
      i_tsp_host.stop();
    end
    chk(16'(n_clr - c0), 16'h4);
    c0 = n_clr;
    i_tsp_host.start();
    wr(tsp_pkg::ALERT_RESP_BYTE);
    i_tsp_host.xfer(8'h00, 1'b1, rd, ak);
    i_tsp_host.stop();
    chk(16'(n_clr - c0), 16'h0);
    tm = 1'b0;
    i_tsp_host.start();
    wr(tsp_pkg::ALERT_RESP_BYTE);
    ca(1'b0);
    i_tsp_host.stop();
  endtask : t_alert

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    tick(12);
    i_rst = 1'b0;
    tick(6);
    t_power_read();
    t_strap();
    t_write();
    t_gcall();
    t_hs();
    t_alert();
    complete_run();
  end
endmodule : tsp_slave_tb

`default_nettype wire
